// *** hdl/fsq_defines.svh ***
// Opcodes, field sizes and timing counts of the flash program sequencer
`ifndef FSQ_DEFINES_SVH
`define FSQ_DEFINES_SVH
`define FSQ_CMD_WREN 8'h06
`define FSQ_CMD_WRDI 8'h04
`define FSQ_CMD_SEQ_A 8'hAD
`define FSQ_CMD_SEQ_B 8'hAF
`define FSQ_CMD_DUAL 8'hA2
`define FSQ_CMD_LAST 3'h7
`define FSQ_ADDR_LAST 5'h17
`define FSQ_SEQ_BYTE_LAST 3'h7
`define FSQ_DUAL_BYTE_LAST 3'h3
`define FSQ_ARRAY_LAST 24'h00FFFF
`define FSQ_CORE_PERIOD_NS 8
`define FSQ_SCK_PERIOD_NS 160
`define FSQ_SCK_HALF_CYC ((`FSQ_SCK_PERIOD_NS / `FSQ_CORE_PERIOD_NS) / 2)
`endif

// *** hdl/fsq_pkg.sv ***
// Types shared by both ends of the flash program link
package fsq_pkg;
  typedef enum logic [1:0] {
    FSQ_D_CMD = 2'b00,
    FSQ_D_ADDR = 2'b01,
    FSQ_D_DATA = 2'b10,
    FSQ_D_SKIP = 2'b11
  } fsq_dev_st_t;
  typedef enum logic [2:0] {
    FSQ_OP_WREN = 3'b000,
    FSQ_OP_WRDI = 3'b001,
    FSQ_OP_SEQ_FIRST = 3'b010,
    FSQ_OP_SEQ_NEXT = 3'b011,
    FSQ_OP_DUAL = 3'b100
  } fsq_op_t;
  typedef enum logic [2:0] {
    FSQ_H_IDLE = 3'b000,
    FSQ_H_LEAD = 3'b001,
    FSQ_H_SHIFT = 3'b010,
    FSQ_H_LOW = 3'b011,
    FSQ_H_HIGH = 3'b100,
    FSQ_H_TAIL = 3'b101,
    FSQ_H_GAP = 3'b110
  } fsq_host_st_t;
endpackage

// *** hdl/fsq_if.sv ***
// Serial flash link between host controller and flash device
`timescale 1ns/1ns
`default_nettype none
interface fsq_if;
  logic sck;
  logic cs_n;
  logic si;
  logic h_so_o;
  logic h_so_oe;
  logic d_so_o;
  logic d_so_oe;
  logic so;
  // Resolved data-out wire, pulled high when nobody drives
  assign so = d_so_oe ? d_so_o : (h_so_oe ? h_so_o : 1'b1);
  modport dev (input sck, cs_n, si, so, output d_so_o, d_so_oe);
  modport host (output sck, cs_n, si, h_so_o, h_so_oe, input so);
endinterface
`default_nettype wire

// *** hdl/fsq_device.sv ***
// Flash device end: sequential and dual-line program command logic
`timescale 1ns/1ns
`default_nettype none

`include "fsq_defines.svh"
// Program request FIFO between page buffer and program engine
module fsq_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage words
  logic [AW:0] wp_q; // Write pointer with wrap bit
  logic [AW:0] rp_q; // Read pointer with wrap bit
  logic push;
  logic pop;
  assign o_ready = (wp_q[AW] == rp_q[AW]) || (wp_q[AW-1:0] != rp_q[AW-1:0]);
  assign o_valid = wp_q != rp_q;
  assign o_data = mem[rp_q[AW-1:0]];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  // Pointer update
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
    end
  end
  // Word store
  always_ff @(posedge i_core_clk) begin
    if (push) mem[wp_q[AW-1:0]] <= i_data;
  end
endmodule

module fsq_device #(
  parameter logic [23:0] ARRAY_LAST = `FSQ_ARRAY_LAST,
  parameter int NBLK = 16
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  fsq_if.dev link,
  input wire logic [NBLK-1:0] i_prot_map,
  input wire logic i_susp_valid,
  input wire logic [3:0] i_susp_blk,
  input wire logic i_err_clr,
  output logic o_pgm_valid,
  input wire logic i_pgm_ready,
  output logic [23:0] o_pgm_addr,
  output logic [7:0] o_pgm_data,
  input wire logic i_pgm_done,
  input wire logic i_pgm_fail,
  output logic o_write_enable_latch,
  output logic o_busy_flag,
  output logic o_seq_mode,
  output logic o_erase_error_flag,
  output logic o_program_error_flag
);
  import fsq_pkg::*;

  logic [3:0] m1_q; // First sync stage: sck, cs_n, si, so
  logic [3:0] m2_q; // Second sync stage
  logic sck_p_q; // Previous synced clock
  logic cs_p_q; // Previous synced select
  fsq_dev_st_t st_q; // Frame field
  logic [4:0] cnt_q; // Clocks within field or byte
  logic [7:0] sh_q; // Byte shifter
  logic [7:0] op_q; // Decoded opcode
  logic go_q; // Command accepted for this frame
  logic [23:0] addr_q; // Received start address
  logic [7:0] wp_q; // Page write offset
  logic [8:0] nb_q; // Received bytes, saturating
  logic [7:0] last_q; // Last sequential byte
  logic [7:0] pbuf [256]; // Page buffer
  logic [255:0] vld_q; // Page buffer entries filled
  logic wel_q; // Write enable latch
  logic seq_q; // Sequential mode
  logic [23:0] sc_q; // Sequential address counter
  logic dr_q; // Draining buffer to FIFO
  logic [7:0] di_q; // Drain index
  logic [23:0] db_q; // Drain base address
  logic [9:0] pend_q; // Requests awaiting verify
  logic ee_q;
  logic pe_q;
  logic bsy_q;
  logic so_oe_q;
  logic rise;
  logic cs_rise;
  logic cs_fall;
  logic busy;
  logic [7:0] nbyte;
  logic bdone;
  logic good;
  logic is_seq;
  logic [23:0] tgt;
  logic [7:0] dpos;
  logic f_valid;
  logic f_ready;
  logic wel_set;
  logic wel_clr;
  logic seq_start;
  logic seq_end;
  logic dual_go;
  logic abort_buf;

  // Block of an address is protected
  function automatic logic prot(input logic [23:0] a);
    prot = i_prot_map[a[19:16]];
  endfunction
  // Block of an address has a suspended erase
  function automatic logic susp(input logic [23:0] a);
    susp = i_susp_valid && (a[19:16] == i_susp_blk);
  endfunction

  // Two-stage synchronisers for link pins
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      m1_q <= 4'h2;
      m2_q <= 4'h2;
      sck_p_q <= 1'b0;
      cs_p_q <= 1'b1;
    end else begin
      m1_q <= {link.so, link.si, link.cs_n, link.sck};
      m2_q <= m1_q;
      sck_p_q <= m2_q[0];
      cs_p_q <= m2_q[1];
    end
  end

  assign rise = m2_q[0] && !sck_p_q && !m2_q[1];
  assign cs_rise = m2_q[1] && !cs_p_q;
  assign cs_fall = !m2_q[1] && cs_p_q;
  assign busy = dr_q || (pend_q != 10'h000);
  assign is_seq = (op_q == `FSQ_CMD_SEQ_A) || (op_q == `FSQ_CMD_SEQ_B);
  // Dual data: high bit on SO, low bit on SI
  assign nbyte = is_seq ? {sh_q[6:0], m2_q[2]} : {sh_q[5:0], m2_q[3], m2_q[2]};
  assign bdone = (st_q == FSQ_D_DATA) && rise &&
    (cnt_q[2:0] == (is_seq ? `FSQ_SEQ_BYTE_LAST : `FSQ_DUAL_BYTE_LAST));
  // Header done, at least one byte, byte boundary
  assign good = (st_q == FSQ_D_DATA) && (cnt_q == 5'h00) && (nb_q != 9'h000);
  // First cycle uses sent address, later ones the counter
  assign tgt = seq_q ? sc_q : addr_q;
  assign dpos = db_q[7:0] + di_q;

  // Frame-end decisions
  always_comb begin
    wel_set = 1'b0;
    wel_clr = 1'b0;
    seq_start = 1'b0;
    seq_end = 1'b0;
    dual_go = 1'b0;
    abort_buf = 1'b0;
    if (cs_rise && go_q) begin
      if (op_q == `FSQ_CMD_WREN) begin
        wel_set = 1'b1;
      end else if (op_q == `FSQ_CMD_WRDI) begin
        wel_clr = 1'b1;
      end else if (is_seq) begin
        if (!good || (!seq_q && prot(addr_q))) begin
          wel_clr = 1'b1;
        end else begin
          seq_start = 1'b1;
          if (tgt == ARRAY_LAST || prot(tgt + 24'h000001)) begin
            wel_clr = 1'b1;
          end
          if (susp(tgt + 24'h000001)) seq_end = 1'b1;
        end
      end else begin
        abort_buf = 1'b1;
        if (!good || prot(addr_q)) begin
          wel_clr = 1'b1;
        end else begin
          dual_go = 1'b1;
          wel_clr = 1'b1;
          abort_buf = 1'b0;
        end
      end
    end
  end

  // Frame receiver: command, address and data fields
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= FSQ_D_CMD;
      cnt_q <= 5'h00;
      sh_q <= 8'h00;
      op_q <= 8'h00;
      go_q <= 1'b0;
      addr_q <= 24'h000000;
      wp_q <= 8'h00;
      nb_q <= 9'h000;
      last_q <= 8'h00;
    end else if (cs_fall) begin
      st_q <= FSQ_D_CMD;
      cnt_q <= 5'h00;
      go_q <= 1'b0;
      wp_q <= 8'h00;
      nb_q <= 9'h000;
    end else if (rise) begin
      unique case (st_q)
        FSQ_D_CMD: begin
          sh_q <= {sh_q[6:0], m2_q[2]};
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q[2:0] == `FSQ_CMD_LAST) begin
            cnt_q <= 5'h00;
            op_q <= {sh_q[6:0], m2_q[2]};
            st_q <= FSQ_D_SKIP;
            unique case ({sh_q[6:0], m2_q[2]})
              `FSQ_CMD_WREN, `FSQ_CMD_WRDI: go_q <= !busy;
              `FSQ_CMD_SEQ_A, `FSQ_CMD_SEQ_B: begin
                go_q <= !busy && (wel_q || seq_q);
                st_q <= seq_q ? FSQ_D_DATA : FSQ_D_ADDR;
              end
              `FSQ_CMD_DUAL: begin
                go_q <= !busy && wel_q && !seq_q;
                st_q <= FSQ_D_ADDR;
              end
              default: go_q <= 1'b0;
            endcase
          end
        end
        FSQ_D_ADDR: begin
          addr_q <= {addr_q[22:0], m2_q[2]};
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == `FSQ_ADDR_LAST) begin
            cnt_q <= 5'h00;
            st_q <= FSQ_D_DATA;
            wp_q <= 8'h00;
          end
        end
        FSQ_D_DATA: begin
          sh_q <= nbyte;
          cnt_q <= bdone ? 5'h00 : cnt_q + 5'h01;
          if (bdone) begin
            last_q <= nbyte;
            wp_q <= wp_q + 8'h01;
            if (nb_q != 9'h100) nb_q <= nb_q + 9'h001;
          end
        end
        // Rest of an unused frame is ignored
        FSQ_D_SKIP: cnt_q <= cnt_q;
      endcase
    end
  end

  // Page buffer writes, wrapping within the page
  always_ff @(posedge i_core_clk) begin
    if (bdone && !is_seq && go_q) pbuf[addr_q[7:0] + wp_q] <= nbyte;
    else if (seq_start) pbuf[tgt[7:0]] <= last_q;
  end

  // Buffer fill marks; overwrites keep only last 256 bytes
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      vld_q <= '0;
    end else if (abort_buf) begin
      vld_q <= '0;
    end else if (bdone && !is_seq && go_q) begin
      vld_q[addr_q[7:0] + wp_q] <= 1'b1;
    end else if (seq_start) begin
      vld_q[tgt[7:0]] <= 1'b1;
    end else if (dr_q && (!vld_q[dpos] || f_ready)) begin
      vld_q[dpos] <= 1'b0;
    end
  end

  // Write enable latch and sequential mode
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wel_q <= 1'b0;
      seq_q <= 1'b0;
      sc_q <= 24'h000000;
    end else begin
      if (wel_clr) wel_q <= 1'b0;
      else if (wel_set) wel_q <= 1'b1;
      if (wel_clr || seq_end) seq_q <= 1'b0;
      else if (seq_start) seq_q <= 1'b1;
      if (seq_start) sc_q <= tgt + 24'h000001;
    end
  end

  // Drain of the buffer to the program engine from start address
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dr_q <= 1'b0;
      di_q <= 8'h00;
      db_q <= 24'h000000;
    end else if (seq_start || dual_go) begin
      dr_q <= 1'b1;
      di_q <= 8'h00;
      db_q <= seq_start ? tgt : addr_q;
    end else if (dr_q && (!vld_q[dpos] || f_ready)) begin
      di_q <= di_q + 8'h01;
      if (di_q == 8'hFF) dr_q <= 1'b0;
    end
  end

  assign f_valid = dr_q && vld_q[dpos];

  fsq_fifo #(.WIDTH(32), .DEPTH(8)) u_fifo (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_valid(f_valid),
    .o_ready(f_ready),
    .i_data({db_q[23:8], dpos, pbuf[dpos]}),
    .o_valid(o_pgm_valid),
    .i_ready(i_pgm_ready),
    .o_data({o_pgm_addr, o_pgm_data})
  );

  // Outstanding programs, verify results and busy
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pend_q <= 10'h000;
      ee_q <= 1'b0;
      pe_q <= 1'b0;
      bsy_q <= 1'b0;
    end else begin
      pend_q <= pend_q + {9'h000, f_valid && f_ready} - {9'h000, i_pgm_done};
      // Set beats clear
      if (i_pgm_done && i_pgm_fail) begin
        ee_q <= 1'b1;
        pe_q <= 1'b1;
      end else if (i_err_clr) begin
        ee_q <= 1'b0;
        pe_q <= 1'b0;
      end
      bsy_q <= busy || seq_start || dual_go;
    end
  end

  // SO driven until dual data phase turns it to input
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) so_oe_q <= 1'b0;
    else so_oe_q <= !m2_q[1] && !(st_q == FSQ_D_DATA && !is_seq);
  end

  assign link.d_so_oe = so_oe_q;
  assign link.d_so_o = bsy_q;
  assign o_write_enable_latch = wel_q;
  assign o_busy_flag = bsy_q;
  assign o_seq_mode = seq_q;
  assign o_erase_error_flag = ee_q;
  assign o_program_error_flag = pe_q;
endmodule
`default_nettype wire

// *** hdl/fsq_host.sv ***
// Host controller end: frames program commands onto the serial link
`timescale 1ns/1ns
`default_nettype none
`include "fsq_defines.svh"
module fsq_host #(
  parameter int HALF = `FSQ_SCK_HALF_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  fsq_if.host link,
  input wire logic i_cmd_valid,
  input wire fsq_pkg::fsq_op_t i_cmd_op,
  input wire logic [23:0] i_cmd_addr,
  input wire logic [8:0] i_cmd_len,
  output logic o_cmd_ready,
  input wire logic i_dat_valid,
  input wire logic [7:0] i_dat,
  output logic o_dat_ready,
  input wire logic i_dev_busy,
  output logic o_done
);
  import fsq_pkg::*;

  fsq_host_st_t st_q; // Link phase
  fsq_op_t op_q; // Pending operation
  logic [23:0] addr_q;
  logic [8:0] len_q;
  logic pre_q; // Write enable frame goes first
  logic [31:0] hdr_q; // Command and address shifter
  logic [5:0] hl_q; // Header clocks left
  logic [8:0] nb_q; // Data bytes left
  logic [7:0] by_q; // Current data byte
  logic [2:0] bl_q; // Data clocks left in byte
  logic [7:0] dv_q; // Half-period counter
  logic sck_q, cs_n_q, si_q, so_q, so_oe_q, rdy_q, dr_q, dn_q;
  logic dual;
  logic [7:0] b;
  logic half_end;

  assign dual = (op_q == FSQ_OP_DUAL) && !pre_q;
  assign b = (bl_q == 3'h0) ? i_dat : by_q;
  assign half_end = dv_q == 8'(HALF - 1);

  // Opcode of the frame about to go out
  function automatic logic [7:0] opc(input fsq_op_t o, input logic p);
    if (p || o == FSQ_OP_WREN) opc = `FSQ_CMD_WREN;
    else if (o == FSQ_OP_WRDI) opc = `FSQ_CMD_WRDI;
    else if (o == FSQ_OP_DUAL) opc = `FSQ_CMD_DUAL;
    else opc = `FSQ_CMD_SEQ_A;
  endfunction

  // Frame sequencer with divided link clock, mode 0
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= FSQ_H_IDLE;
      op_q <= FSQ_OP_WREN;
      addr_q <= 24'h000000;
      len_q <= 9'h000;
      pre_q <= 1'b0;
      hdr_q <= 32'h00000000;
      hl_q <= 6'h00;
      nb_q <= 9'h000;
      by_q <= 8'h00;
      bl_q <= 3'h0;
      dv_q <= 8'h00;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      si_q <= 1'b0;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
      rdy_q <= 1'b0;
      dr_q <= 1'b0;
      dn_q <= 1'b0;
    end else begin
      dr_q <= 1'b0;
      dn_q <= 1'b0;
      dv_q <= dv_q + 8'h01;
      unique case (st_q)
        FSQ_H_IDLE: begin
          rdy_q <= !i_dev_busy;
          if (i_cmd_valid && rdy_q && !i_dev_busy) begin
            rdy_q <= 1'b0;
            op_q <= i_cmd_op;
            addr_q <= i_cmd_addr;
            len_q <= (i_cmd_len == 9'h000) ? 9'h001 : i_cmd_len;
            pre_q <= i_cmd_op == FSQ_OP_DUAL;
            st_q <= FSQ_H_LEAD;
            dv_q <= 8'h00;
          end
        end
        FSQ_H_LEAD: begin
          cs_n_q <= 1'b0;
          // Header MSB first; restart carries full address
          hdr_q <= {opc(op_q, pre_q), addr_q};
          hl_q <= (pre_q || op_q == FSQ_OP_WREN || op_q == FSQ_OP_WRDI
            || op_q == FSQ_OP_SEQ_NEXT) ? 6'h08 : 6'h20;
          nb_q <= (pre_q || op_q == FSQ_OP_WREN || op_q == FSQ_OP_WRDI) ? 9'h000 :
            ((op_q == FSQ_OP_DUAL) ? len_q : 9'h001);
          bl_q <= 3'h0;
          if (half_end) st_q <= FSQ_H_SHIFT;
        end
        FSQ_H_SHIFT: begin
          dv_q <= 8'h00;
          if (hl_q != 6'h00) begin
            si_q <= hdr_q[31];
            hdr_q <= {hdr_q[30:0], 1'b0};
            hl_q <= hl_q - 6'h01;
            st_q <= FSQ_H_LOW;
          end else if (bl_q != 3'h0 || i_dat_valid) begin
            dr_q <= bl_q == 3'h0;
            if (bl_q == 3'h0) nb_q <= nb_q - 9'h001;
            st_q <= FSQ_H_LOW;
            if (dual) begin
              // High bit on SO, low on SI
              so_oe_q <= 1'b1;
              so_q <= b[7];
              si_q <= b[6];
              by_q <= {b[5:0], 2'b00};
              bl_q <= (bl_q == 3'h0) ? `FSQ_DUAL_BYTE_LAST : bl_q - 3'h1;
            end else begin
              si_q <= b[7];
              by_q <= {b[6:0], 1'b0};
              bl_q <= (bl_q == 3'h0) ? `FSQ_SEQ_BYTE_LAST : bl_q - 3'h1;
            end
          end
        end
        FSQ_H_LOW: begin
          if (half_end) begin
            sck_q <= 1'b1;
            dv_q <= 8'h00;
            st_q <= FSQ_H_HIGH;
          end
        end
        FSQ_H_HIGH: begin
          if (half_end) begin
            sck_q <= 1'b0;
            dv_q <= 8'h00;
            // Only whole bytes end a frame
            st_q <= (hl_q == 6'h00 && bl_q == 3'h0 && nb_q == 9'h000) ?
              FSQ_H_TAIL : FSQ_H_SHIFT;
          end
        end
        FSQ_H_TAIL: begin
          if (half_end) begin
            cs_n_q <= 1'b1;
            so_oe_q <= 1'b0;
            dv_q <= 8'h00;
            st_q <= FSQ_H_GAP;
          end
        end
        FSQ_H_GAP: begin
          if (half_end) begin
            dv_q <= 8'h00;
            if (pre_q) begin
              pre_q <= 1'b0;
              st_q <= FSQ_H_LEAD;
            end else begin
              dn_q <= 1'b1;
              st_q <= FSQ_H_IDLE;
            end
          end
        end
        default: st_q <= FSQ_H_IDLE;
      endcase
    end
  end

  assign link.sck = sck_q;
  assign link.cs_n = cs_n_q;
  assign link.si = si_q;
  assign link.h_so_o = so_q;
  assign link.h_so_oe = so_oe_q;
  assign o_cmd_ready = rdy_q;
  assign o_dat_ready = dr_q;
  assign o_done = dn_q;
endmodule
`default_nettype wire

// *** dv/fsq_sva.sv ***
// Checker for the serial program link between host and device
`timescale 1ns/1ns
`default_nettype none
`include "fsq_defines.svh"
module fsq_sva (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic h_so_oe,
  input wire logic d_so_oe
);
  logic sck_q; // Link clock one cycle ago
  logic cs_q; // Select one cycle ago
  logic [11:0] cnt_q; // Link clocks seen in the current frame
  logic [7:0] cmd_q; // Opcode of the current frame
  // Count link clock rises per frame and capture the opcode
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sck_q <= 1'b0;
      cs_q <= 1'b1;
      cnt_q <= 12'h000;
      cmd_q <= 8'h00;
    end else begin
      sck_q <= sck;
      cs_q <= cs_n;
      // Frame start clears the count
      if (!cs_n && cs_q) begin
        cnt_q <= 12'h000;
      end else if (!cs_n && sck && !sck_q) begin
        cnt_q <= cnt_q + 12'h001;
        if (cnt_q < 12'h008) begin
          cmd_q <= {cmd_q[6:0], si};
        end
      end
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  property p_no_fight; !(h_so_oe && d_so_oe); endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("both ends drive the data-out wire");
  property p_idle_clk; cs_n |-> !sck; endproperty
  a_idle_clk: assert property (p_idle_clk)
    else $error("link clock high outside a frame");
  property p_lead; $fell(cs_n) |-> !sck [*4]; endproperty
  a_lead: assert property (p_lead)
    else $error("link clock rose too soon after select");
  property p_si_hold; sck && sck_q |-> $stable(si); endproperty
  a_si_hold: assert property (p_si_hold)
    else $error("serial input changed while clock high");
  property p_byte_end;
    $rose(cs_n) && cmd_q != `FSQ_CMD_DUAL |-> cnt_q[2:0] == 3'h0 && cnt_q >= 12'h008;
  endproperty
  a_byte_end: assert property (p_byte_end)
    else $error("frame ended off a byte boundary");
  property p_dual_end;
    $rose(cs_n) && cmd_q == `FSQ_CMD_DUAL |-> cnt_q[1:0] == 2'h0 && cnt_q >= 12'h024;
  endproperty
  a_dual_end: assert property (p_dual_end)
    else $error("dual frame ended without whole data bytes");
  property p_host_so; h_so_oe |-> cmd_q == `FSQ_CMD_DUAL && cnt_q >= 12'h020; endproperty
  a_host_so: assert property (p_host_so)
    else $error("host drove data-out before the dual data phase");
  // Only dual frames turn the data-out wire around
  property p_dev_so; d_so_oe && !cs_n && cmd_q == `FSQ_CMD_DUAL |-> cnt_q <= 12'h020; endproperty
  a_dev_so: assert property (p_dev_so)
    else $error("device still drives data-out after the header");
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Bench joining host and device over the program link
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import fsq_pkg::*;
  logic i_core_clk = 1'b0; // Core clock
  logic i_reset_n = 1'b0; // Reset, active low
  integer seed = 32'h8017A2A4; // Fixed seed
  int n_fail = 0; // Mismatches
  int check_count = 0; // Comparisons
  int cycles = 0; // Clock cycles run
  logic cmd_valid = 1'b0, dat_valid = 1'b0, cmd_ready, dat_ready, done;
  fsq_op_t cmd_op = FSQ_OP_WREN;
  logic [23:0] cmd_addr = 24'h000000;
  logic [8:0] cmd_len = 9'h000;
  logic [7:0] dat = 8'h00;
  logic [15:0] prot = 16'h0000; // Protected blocks
  logic susp_v = 1'b0, err_clr = 1'b0, fail_on = 1'b0;
  logic [3:0] susp_b = 4'h0;
  logic pgm_valid, pgm_ready = 1'b0, pgm_done = 1'b0, pgm_fail = 1'b0;
  logic [23:0] pgm_addr;
  logic [7:0] pgm_data;
  logic write_enable_latch, busy, seq, ee, pe;
  logic [7:0] tx_q[$]; // Bytes waiting for the host
  logic [31:0] got_q[$], exp_q[$]; // Programmed {address, data}
  fsq_if link_if ();
  fsq_host fsq_host_inst (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .link(link_if),
    .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op), .i_cmd_addr(cmd_addr), .i_cmd_len(cmd_len),
    .o_cmd_ready(cmd_ready), .i_dat_valid(dat_valid), .i_dat(dat), .o_dat_ready(dat_ready),
    .i_dev_busy(busy), .o_done(done));
  fsq_device fsq_device_inst (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .link(link_if), .i_prot_map(prot), .i_susp_valid(susp_v), .i_susp_blk(susp_b), .i_err_clr(err_clr),
    .o_pgm_valid(pgm_valid), .i_pgm_ready(pgm_ready), .o_pgm_addr(pgm_addr), .o_pgm_data(pgm_data),
    .i_pgm_done(pgm_done), .i_pgm_fail(pgm_fail), .o_write_enable_latch(write_enable_latch), .o_busy_flag(busy),
    .o_seq_mode(seq), .o_erase_error_flag(ee), .o_program_error_flag(pe));
  fsq_sva fsq_sva_inst (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .sck(link_if.sck),
    .cs_n(link_if.cs_n), .si(link_if.si), .h_so_oe(link_if.h_so_oe), .d_so_oe(link_if.d_so_oe));
  always #4 i_core_clk = ~i_core_clk;
  // Byte feeder, stalling program engine and hang limit
  always @(posedge i_core_clk) begin
    logic take, pop;
    take = pgm_valid && pgm_ready;
    pop = dat_ready && dat_valid;
    if (take) got_q.push_back({pgm_addr, pgm_data});
    #1;
    if (pop) void'(tx_q.pop_front());
    dat_valid = tx_q.size() != 0;
    dat = dat_valid ? tx_q[0] : 8'h00;
    pgm_done = take;
    pgm_fail = take && fail_on;
    pgm_ready = ($random(seed) & 3) != 0;
    cycles++;
    if (cycles > 80000) begin
      n_fail++;
      print_verdict();
    end
  end
  // Compare seen against wanted
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      n_fail++;
      $display("mismatch at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  // Slot of the k-th byte, wrapping inside the start page
  function automatic logic [23:0] slot_addr(input logic [23:0] a, input int k);
    slot_addr = {a[23:8], a[7:0] + 8'(k)};
  endfunction
  // Last sent byte that lands in slot k
  function automatic int last_idx(input int n, input int k);
    last_idx = k;
    while (last_idx + 256 < n) last_idx += 256;
  endfunction
  // One host command with n random bytes; pg says programming is due
  task automatic run(input fsq_op_t op, input logic [23:0] a, input int n, input bit pg);
    logic [7:0] b[$];
    for (int k = 0; k < n; k++) b.push_back(8'($random(seed)));
    tx_q = b;
    // Page wrap; later bytes overwrite earlier ones
    for (int k = 0; pg && k < (n > 256 ? 256 : n); k++) begin
      exp_q.push_back({slot_addr(a, k), b[last_idx(n, k)]});
    end
    cmd_op = op;
    cmd_addr = a;
    cmd_len = 9'(n);
    cmd_valid = 1'b1;
    do @(posedge i_core_clk); while (!(cmd_ready && !busy));
    #1 cmd_valid = 1'b0;
    do @(posedge i_core_clk); while (!done);
    do @(posedge i_core_clk); while (busy);
    #1;
    check(32'(got_q.size()), 32'(exp_q.size()));
    while (exp_q.size() != 0 && got_q.size() != 0) check(got_q.pop_front(), exp_q.pop_front());
    got_q = {};
    exp_q = {};
  endtask
  // Counts, verdict, end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge i_core_clk);
    #1 i_reset_n = 1'b1;
    repeat (2) @(posedge i_core_clk);
    #1;
    run(FSQ_OP_DUAL, 24'h0000FE, 3, 1);
    check({31'h0, write_enable_latch}, 32'h0);
    run(FSQ_OP_DUAL, {8'h01, 16'($random(seed))}, 258, 1);
    repeat (3) run(FSQ_OP_DUAL, {8'h00, 16'($random(seed))}, 1 + ($random(seed) & 15), 1);
    prot = 16'h0004;
    run(FSQ_OP_DUAL, 24'h020010, 2, 0);
    check({31'h0, write_enable_latch}, 32'h0);
    run(FSQ_OP_WREN, 24'h000000, 0, 0);
    check({31'h0, write_enable_latch}, 32'h1);
    run(FSQ_OP_SEQ_FIRST, 24'h020000, 1, 0);
    check({30'h0, write_enable_latch, seq}, 32'h0);
    run(FSQ_OP_WREN, 24'h000000, 0, 0);
    run(FSQ_OP_SEQ_FIRST, 24'h01FFFE, 1, 1);
    check({30'h0, write_enable_latch, seq}, 32'h3);
    run(FSQ_OP_SEQ_NEXT, 24'h01FFFF, 1, 1);
    check({30'h0, write_enable_latch, seq}, 32'h0);
    susp_v = 1'b1;
    susp_b = 4'h5;
    run(FSQ_OP_WREN, 24'h000000, 0, 0);
    run(FSQ_OP_SEQ_FIRST, 24'h04FFFF, 1, 1);
    check({31'h0, seq}, 32'h0);
    run(FSQ_OP_WREN, 24'h000000, 0, 0);
    run(FSQ_OP_SEQ_FIRST, 24'h00FFFF, 1, 1);
    check({30'h0, write_enable_latch, seq}, 32'h0);
    run(FSQ_OP_WREN, 24'h000000, 0, 0);
    run(FSQ_OP_SEQ_FIRST, 24'h001000, 1, 1);
    run(FSQ_OP_WRDI, 24'h000000, 0, 0);
    check({30'h0, write_enable_latch, seq}, 32'h0);
    fail_on = 1'b1;
    run(FSQ_OP_DUAL, 24'h003000, 1, 1);
    check({30'h0, ee, pe}, 32'h3);
    fail_on = 1'b0;
    err_clr = 1'b1;
    @(posedge i_core_clk) #1 err_clr = 1'b0;
    check({30'h0, ee, pe}, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
